// ===== hw/glk_lock_detector.sv
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "glk_regs.svh"

// Behaviour
// R01: lock-failure pin high unless reference valid and both locks set.
// R02: reference-missing pin is always the inverse of reference valid.
// R03: reference validity judged from H sync alone, vertical sync unused.
// R04: software programs dividers to match the reference format.
// R05: reference invalid while oscillator control voltage is near a rail.
// R06: missing-pulse error field bounds absent H pulses before loss.
// R07: loss threshold is error field times divider: 00=2, 01=1, 10=5.
// R08: error field zero declares loss on the first missing pulse.
// R09: past threshold flag loss, free-run or holdover while absent.
// R10: standard lock from oscillator loop, hi-def lock from VCO loop.
// R11: lock-threshold field is the largest allowed phase error.
// R12: compare divided H sync against divided oscillator clock.
// R13: unlock only after three consecutive over-threshold comparisons.
// R14: lock only after three consecutive under-threshold comparisons.
// R15: charge pump current is code times 31.25 uA, default 08h.
// R16: reference valid and locks readable as status and on pins.
// R17: software should raise lock threshold for jittery references.
// R18: on reference loss keep hi-def lock, clear standard lock, valid.
// R19: an H pulse in its window clears the missing-pulse count.
// R20: a contradicting comparison restarts the three-period counters.
module glk_lock_detector #(
   parameter int TIMER_W = 16,
   parameter int FBDIV_W = 13
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins from outside
   input wire logic hsync_in,
   input wire logic vc_near_rail,
   input wire logic hd_vco_locked,
   // status pins
   output logic ref_missing,
   output logic lock_failure,
   output logic freerun_active,
   output logic holdover_active,
   output logic [12:0] cp_current_qua
);

   // registers
   logic genlock_en;
   logic holdover_sel;
   logic [2:0] h_error;
   logic [1:0] ref_div_code;
   logic [FBDIV_W-1:0] feedback_divider_value;
   logic [4:0] lock_threshold;
   logic [4:0] charge_pump_current_code;

   // synchronisers
   logic [1:0] hs_sync;
   logic [1:0] rail_sync;
   logic [1:0] hd_sync;
   logic hs_last;
   logic hs_rise;

   // reference detector
   logic [TIMER_W-1:0] line_timer;
   logic [TIMER_W-1:0] line_len;
   logic line_known;
   logic [5:0] miss_cnt;
   logic [5:0] lor_limit;
   logic [2:0] div_value;
   logic div_ok;
   logic lor;
   logic ref_valid;

   // phase detector
   logic [2:0] ref_div_cnt;
   logic ref_pulse;
   logic [FBDIV_W-1:0] fb_cnt;
   logic [FBDIV_W-1:0] phase_err;
   logic over_thr;
   logic [1:0] good_run;
   logic [1:0] bad_run;
   logic std_clock_lock_bit;
   logic hi_def_clock_lock_bit;
   glk_pkg::glk_op_e op_state;

   // bus
   logic aw_held;
   logic w_held;
   logic [4:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic wr_hit;
   logic [31:0] rd_word;
   logic rd_hit;

   // only the second stage is read by logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hs_sync <= 2'h0;
         rail_sync <= 2'h0;
         hd_sync <= 2'h0;
         hs_last <= 1'b0;
      end else begin
         hs_sync <= {hs_sync[0], hsync_in};
         rail_sync <= {rail_sync[0], vc_near_rail};
         hd_sync <= {hd_sync[0], hd_vco_locked};
         hs_last <= hs_sync[1];
      end
   end

   // vertical sync has no say in reference detection
   assign hs_rise = hs_sync[1] & ~hs_last; // R03

   always_comb begin
      case (ref_div_code)
         `GLK_DIV_CODE_2: div_value = 3'h2; // R07
         `GLK_DIV_CODE_1: div_value = 3'h1; // R07
         `GLK_DIV_CODE_5: div_value = 3'h5; // R07
         default: div_value = 3'h1;
      endcase
   end

   // code 11 has no divider, so the reference cannot be valid with it
   assign div_ok = (ref_div_code != 2'h3); // R04
   assign lor_limit = 6'(h_error * div_value); // R06 R07

   // line length learnt from the last gap; a miss is 1.5 lines silent
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_timer <= '0;
         line_len <= '0;
         line_known <= 1'b0;
      end else if (hs_rise) begin
         line_timer <= '0;
         line_len <= line_timer;
         line_known <= 1'b1;
      end else if (line_known && line_len != '0 &&
                   line_timer >= line_len + (line_len >> 1)) begin
         // step back one line so later misses fall a whole line apart
         line_timer <= line_timer - line_len;
      end else if (line_timer != '1) begin
         line_timer <= line_timer + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // no line is known out of reset, so the reference starts lost
         miss_cnt <= '1;
      end else if (hs_rise) begin
         miss_cnt <= '0; // R19
      end else if (!line_known || (line_timer == '1)) begin
         miss_cnt <= '1;
      end else if (line_len != '0 &&
                   line_timer >= line_len + (line_len >> 1) &&
                   miss_cnt != '1) begin
         miss_cnt <= miss_cnt + 1'b1; // R06
      end
   end

   // strict compare: a zero field trips on the first miss
   assign lor = (miss_cnt > lor_limit); // R08 R09

   assign ref_valid = genlock_en & div_ok & ~lor & ~rail_sync[1]; // R05

   // reference side of the phase detector
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_div_cnt <= '0;
      end else if (hs_rise) begin
         if (ref_div_cnt + 3'h1 >= div_value) begin
            ref_div_cnt <= '0;
         end else begin
            ref_div_cnt <= ref_div_cnt + 3'h1;
         end
      end
   end

   assign ref_pulse = hs_rise && (ref_div_cnt + 3'h1 >= div_value); // R12

   // feedback side: clock divided by the feedback divider
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fb_cnt <= '0;
      end else if (fb_cnt + 1'b1 >= feedback_divider_value) begin
         fb_cnt <= '0; // R12
      end else begin
         fb_cnt <= fb_cnt + 1'b1;
      end
   end

   // distance to the nearest feedback edge, early or late
   always_comb begin
      if (fb_cnt > (feedback_divider_value >> 1)) begin
         phase_err = feedback_divider_value - fb_cnt;
      end else begin
         phase_err = fb_cnt;
      end
   end

   assign over_thr = (phase_err > FBDIV_W'(lock_threshold)); // R11

   // runs of three decide; a contrary period restarts the other run
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         good_run <= '0;
         bad_run <= '0;
         std_clock_lock_bit <= 1'b0;
      end else if (!ref_valid) begin
         good_run <= '0;
         bad_run <= '0;
         std_clock_lock_bit <= 1'b0; // R18
      end else if (ref_pulse) begin
         if (over_thr) begin
            good_run <= '0; // R20
            if (bad_run + 2'h1 == `GLK_LOCK_RUN) begin
               bad_run <= '0;
               std_clock_lock_bit <= 1'b0; // R13
            end else begin
               bad_run <= bad_run + 2'h1;
            end
         end else begin
            bad_run <= '0; // R20
            if (good_run + 2'h1 == `GLK_LOCK_RUN) begin
               good_run <= '0;
               std_clock_lock_bit <= 1'b1; // R10 R14
            end else begin
               good_run <= good_run + 2'h1;
            end
         end
      end
   end

   // the VCO loop keeps running on the oscillator during loss
   assign hi_def_clock_lock_bit = hd_sync[1]; // R10 R18

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_state <= glk_pkg::GLK_OP_LOCKING;
      end else begin
         case (op_state)
            glk_pkg::GLK_OP_LOCKING,
            glk_pkg::GLK_OP_LOCKED: begin
               if (genlock_en && !ref_valid) begin
                  op_state <= holdover_sel ? glk_pkg::GLK_OP_HOLDOVER
                                           : glk_pkg::GLK_OP_FREERUN; // R09
               end else if (std_clock_lock_bit) begin
                  op_state <= glk_pkg::GLK_OP_LOCKED;
               end else begin
                  op_state <= glk_pkg::GLK_OP_LOCKING;
               end
            end
            glk_pkg::GLK_OP_FREERUN,
            glk_pkg::GLK_OP_HOLDOVER: begin
               if (ref_valid || !genlock_en) begin
                  op_state <= glk_pkg::GLK_OP_LOCKING;
               end else begin
                  op_state <= holdover_sel ? glk_pkg::GLK_OP_HOLDOVER
                                           : glk_pkg::GLK_OP_FREERUN; // R09
               end
            end
            default: op_state <= glk_pkg::GLK_OP_LOCKING;
         endcase
      end
   end

   assign freerun_active = (op_state == glk_pkg::GLK_OP_FREERUN); // R09
   assign holdover_active = (op_state == glk_pkg::GLK_OP_HOLDOVER); // R09

   assign ref_missing = ~ref_valid; // R02 R16
   assign lock_failure = ~(ref_valid & std_clock_lock_bit &
                           hi_def_clock_lock_bit); // R01 R16

   // quarter microamps keep the 31.25 uA step exact
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cp_current_qua <= 13'(`GLK_RST_ICP * `GLK_ICP_STEP_QUA);
      end else begin
         cp_current_qua <= 13'(charge_pump_current_code *
                               `GLK_ICP_STEP_QUA); // R15
      end
   end

   // write channel: address and data taken in either order
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign do_write = aw_held & w_held & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_comb begin
      case ({aw_addr[4:2], 2'h0})
         `GLK_OFF_CTRL, `GLK_OFF_DIV, `GLK_OFF_FBDIV,
         `GLK_OFF_LOCK, `GLK_OFF_STATUS, `GLK_OFF_ICP: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= glk_pkg::GLK_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? glk_pkg::GLK_RESP_OKAY
                               : glk_pkg::GLK_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // status is read only; writes to it are accepted and dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         genlock_en <= `GLK_RST_GNLK;
         holdover_sel <= `GLK_RST_HOLD;
         h_error <= `GLK_RST_HERR;
         ref_div_code <= `GLK_RST_DIV;
         feedback_divider_value <= FBDIV_W'(`GLK_RST_FBDIV);
         lock_threshold <= `GLK_RST_LOCK;
         charge_pump_current_code <= `GLK_RST_ICP;
      end else if (do_write && w_strb[0]) begin
         case ({aw_addr[4:2], 2'h0})
            `GLK_OFF_CTRL: begin
               genlock_en <= w_data[`GLK_CTRL_GNLK];
               holdover_sel <= w_data[`GLK_CTRL_HOLD];
               h_error <= w_data[`GLK_CTRL_HERR_HI:`GLK_CTRL_HERR_LO];
            end
            `GLK_OFF_DIV: ref_div_code <= w_data[1:0];
            `GLK_OFF_FBDIV: begin
               feedback_divider_value[7:0] <= w_data[7:0];
               if (w_strb[1]) begin
                  feedback_divider_value[FBDIV_W-1:8] <=
                     w_data[FBDIV_W-1:8];
               end
            end
            `GLK_OFF_LOCK: lock_threshold <= w_data[4:0];
            `GLK_OFF_ICP: charge_pump_current_code <= w_data[4:0];
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      case ({s_axi_araddr[4:2], 2'h0})
         `GLK_OFF_CTRL: begin
            rd_word[`GLK_CTRL_GNLK] = genlock_en;
            rd_word[`GLK_CTRL_HOLD] = holdover_sel;
            rd_word[`GLK_CTRL_HERR_HI:`GLK_CTRL_HERR_LO] = h_error;
         end
         `GLK_OFF_DIV: rd_word[1:0] = ref_div_code;
         `GLK_OFF_FBDIV: rd_word[FBDIV_W-1:0] = feedback_divider_value;
         `GLK_OFF_LOCK: rd_word[4:0] = lock_threshold;
         `GLK_OFF_STATUS: begin
            rd_word[`GLK_ST_REF] = ref_valid; // R16
            rd_word[`GLK_ST_STD] = std_clock_lock_bit; // R16
            rd_word[`GLK_ST_HD] = hi_def_clock_lock_bit; // R16
            rd_word[`GLK_ST_OP_HI:`GLK_ST_OP_LO] = op_state;
         end
         `GLK_OFF_ICP: rd_word[4:0] = charge_pump_current_code;
         default: rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= glk_pkg::GLK_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? glk_pkg::GLK_RESP_OKAY
                               : glk_pkg::GLK_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : glk_lock_detector

`default_nettype wire

// ===== inc/glk_pkg.sv
package glk_pkg;

   // operating state shown in status
   typedef enum logic [1:0] {
      GLK_OP_LOCKING,
      GLK_OP_LOCKED,
      GLK_OP_FREERUN,
      GLK_OP_HOLDOVER
   } glk_op_e;

   typedef logic [1:0] glk_resp_t;

   localparam glk_resp_t GLK_RESP_OKAY = 2'h0;
   localparam glk_resp_t GLK_RESP_SLVERR = 2'h2;

endpackage : glk_pkg

// ===== inc/glk_regs.svh
`ifndef GLK_REGS_SVH
`define GLK_REGS_SVH

// register byte offsets
`define GLK_OFF_CTRL 5'h00
`define GLK_OFF_DIV 5'h04
`define GLK_OFF_FBDIV 5'h08
`define GLK_OFF_LOCK 5'h0c
`define GLK_OFF_STATUS 5'h10
`define GLK_OFF_ICP 5'h14

// control register fields
`define GLK_CTRL_GNLK 0
`define GLK_CTRL_HOLD 1
`define GLK_CTRL_HERR_LO 2
`define GLK_CTRL_HERR_HI 4

// status register fields
`define GLK_ST_REF 0
`define GLK_ST_STD 1
`define GLK_ST_HD 2
`define GLK_ST_OP_LO 3
`define GLK_ST_OP_HI 4

// reset values
`define GLK_RST_GNLK 1'b1
`define GLK_RST_HOLD 1'b0
`define GLK_RST_HERR 3'h3
`define GLK_RST_DIV 2'h1
`define GLK_RST_FBDIV 13'h06b4
`define GLK_RST_LOCK 5'h10
`define GLK_RST_ICP 5'h08

// reference divider codes
`define GLK_DIV_CODE_2 2'h0
`define GLK_DIV_CODE_1 2'h1
`define GLK_DIV_CODE_5 2'h2

// charge pump step in quarter microamps (31.25 uA)
`define GLK_ICP_STEP_QUA 8'h7d
// consecutive comparison periods for a lock decision
`define GLK_LOCK_RUN 2'h3

`endif

// ===== test/glk_hsync_src.sv
`timescale 1ns/1ns
`default_nettype none
module glk_hsync_src (
   // clock and control
   input wire logic aclk,
   input wire logic run,
   input wire logic [7:0] len,
   // sync pin
   output logic hsync_in
);
   logic [7:0] cnt;
   initial cnt = 8'h00;
   initial hsync_in = 1'b0;
   // line counter runs free so a paused source resumes on the line grid
   always @(posedge aclk) begin
      cnt <= (cnt + 8'h01 >= len) ? 8'h00 : cnt + 8'h01;
      hsync_in <= run && cnt < 8'h04;
   end
endmodule : glk_hsync_src
`default_nettype wire

// ===== test/glk_lock_detector_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module glk_lock_detector_monitor (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // pins
   input wire logic vc_near_rail,
   input wire logic hd_vco_locked,
   input wire logic ref_missing,
   input wire logic lock_failure,
   input wire logic freerun_active,
   input wire logic holdover_active,
   input wire logic [12:0] cp_current_qua
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // inputs pass two sync flops, so allow a few edges of settling
   sequence rail_held;
      vc_near_rail [*5];
   endsequence
   sequence hd_down;
      !hd_vco_locked [*4];
   endsequence
   write_answer_a: assert property (wr_take |=> ##1 s_axi_bvalid)
      else $error("write response not two cycles after handshake");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   read_answer_a: assert property (rd_take |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
   fail_pin_a: assert property (ref_missing |-> lock_failure)
      else $error("lock failure low without valid reference");
   hd_fail_a: assert property (hd_down |-> lock_failure)
      else $error("lock failure low while hd loop unlocked");
   rail_lost_a: assert property (rail_held |-> ref_missing)
      else $error("reference valid with control voltage at rail");
   state_excl_a: assert property (!(freerun_active && holdover_active))
      else $error("free run and holdover both active");
   lost_state_a: assert property ($rose(ref_missing) |->
      ##[1:2] (freerun_active || holdover_active))
      else $error("no free run or holdover after reference loss");
   back_state_a: assert property ($fell(ref_missing) |->
      ##[1:2] (!freerun_active && !holdover_active))
      else $error("free run or holdover kept after reference return");
   cp_map_a: assert property (cp_current_qua % 13'h007d == 13'h0000 &&
      cp_current_qua <= 13'h0f23)
      else $error("charge pump current off the linear code scale");
endmodule : glk_lock_detector_monitor
bind glk_lock_detector glk_lock_detector_monitor
   glk_lock_detector_monitor_inst (.*);
`default_nettype wire

// ===== test/glk_lock_detector_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module glk_lock_detector_tb_top;
   logic aclk, aresetn, hsync_in, vc_near_rail, hd_vco_locked, run;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic ref_missing, lock_failure, freerun_active, holdover_active;
   logic [12:0] cp_current_qua;
   logic [1:0] bq[$];
   logic [33:0] rq[$];
   int n_fail = 0;
   int num_checks = 0;
   int seed = 32'h02b9;

   glk_lock_detector glk_lock_detector_inst (.*);
   // line of 40 clocks keeps every loss window short
   glk_hsync_src glk_hsync_src_inst (.len(8'h28), .*);

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   task automatic tmo();
      n_fail++;
      results();
   endtask : tmo

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask : cyc

   task automatic wait_lvl(ref logic s, input logic v, input int lim,
         output int n);
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge aclk);
         n++;
      end
      if (n >= lim) tmo();
   endtask : wait_lvl

   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
         input logic [1:0] e);
      int n;
      n = 0;
      bq.push_back(e);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
      s_axi_bready <= 1'b0;
      // an edge passes so a following call never drives bready twice at once
      @(posedge aclk);
      if (n >= 50) tmo();
   endtask : axi_wr

   task automatic axi_rd(input logic [4:0] a, input logic [31:0] d,
         input logic [1:0] e);
      int n;
      n = 0;
      rq.push_back({e, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
      if (n >= 50) tmo();
   endtask : axi_rd

   // answers are matched against the oldest note of the driver
   always @(posedge aclk) begin
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
         chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
   end

   initial begin
      logic [4:0] c;
      logic [1:0] dv [4];
      logic [2:0] he [4];
      int t;
      int m;
      dv = '{2'h1, 2'h0, 2'h2, 2'h1};
      he = '{3'h3, 3'h1, 3'h1, 3'h0};
      aresetn = 1'b0;
      s_axi_awaddr = 5'h00;
      s_axi_araddr = 5'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      vc_near_rail = 1'b0;
      hd_vco_locked = 1'b1;
      run = 1'b0;
      cyc(2);
      aresetn <= 1'b1;
      chk(ref_missing, 1'b1);
      chk(lock_failure, 1'b1);
      chk(cp_current_qua, 13'h03e8);
      axi_rd(5'h00, 32'h0d, 2'h0);
      axi_rd(5'h04, 32'h01, 2'h0);
      axi_rd(5'h08, 32'h06b4, 2'h0);
      axi_rd(5'h0c, 32'h10, 2'h0);
      axi_rd(5'h14, 32'h08, 2'h0);
      axi_rd(5'h18, 32'h0, 2'h2);
      axi_wr(5'h18, 32'h0, 2'h2);
      axi_wr(5'h10, 32'h1f, 2'h0);
      axi_rd(5'h10, 32'h14, 2'h0);
      for (int i = 0; i < 6; i++) begin
         c = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($random(seed));
         axi_wr(5'h14, {27'h0, c}, 2'h0);
         chk(cp_current_qua, 13'(c) * 13'h007d);
      end
      // one feedback period per line; a wide threshold always agrees
      axi_wr(5'h08, 32'h28, 2'h0);
      axi_wr(5'h0c, 32'h1f, 2'h0);
      run <= 1'b1;
      wait_lvl(lock_failure, 1'b0, 800, t);
      cyc(2);
      axi_rd(5'h10, 32'h0f, 2'h0);
      hd_vco_locked <= 1'b0;
      cyc(4);
      chk(lock_failure, 1'b1);
      hd_vco_locked <= 1'b1;
      wait_lvl(lock_failure, 1'b0, 10, t);
      vc_near_rail <= 1'b1;
      cyc(6);
      chk(ref_missing, 1'b1);
      vc_near_rail <= 1'b0;
      wait_lvl(ref_missing, 1'b0, 20, t);
      wait_lvl(lock_failure, 1'b0, 800, t);
      // zero threshold with a drifting feedback phase
      axi_wr(5'h0c, 32'h0, 2'h0);
      axi_wr(5'h08, 32'h25, 2'h0);
      wait_lvl(lock_failure, 1'b1, 1600, t);
      chk(ref_missing, 1'b0);
      axi_wr(5'h08, 32'h28, 2'h0);
      axi_wr(5'h00, 32'h05, 2'h0);
      for (int i = 0; i < 2; i++) begin
         wait_lvl(hsync_in, 1'b1, 60, t);
         run <= 1'b0;
         cyc(45);
         run <= 1'b1;
         cyc(40);
         chk(ref_missing, 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         axi_wr(5'h04, {30'h0, dv[i]}, 2'h0);
         axi_wr(5'h00, {27'h0, he[i], 1'(i), 1'b1}, 2'h0);
         run <= 1'b1;
         wait_lvl(ref_missing, 1'b0, 400, t);
         cyc(160);
         wait_lvl(hsync_in, 1'b1, 60, t);
         run <= 1'b0;
         m = (dv[i] == 2'h0) ? 2 : (dv[i] == 2'h1) ? 1 : 5;
         m = m * he[i];
         wait_lvl(ref_missing, 1'b1, 600, t);
         chk(t > 40 * m + 40 && t < 40 * m + 80, 1'b1);
         cyc(2);
         chk({holdover_active, freerun_active}, {i[0], ~i[0]});
         axi_rd(5'h10, {27'h0, 1'b1, i[0], 3'h4}, 2'h0);
      end
      results();
   end
endmodule : glk_lock_detector_tb_top
`default_nettype wire
